//--- hw/scg_map.svh
// Purpose: Register offsets, field masks, reset values and limits of the
//          system clock divide, clock output, monitor and gating block.
// Assumes: Byte addresses on a 32-bit APB, one aligned word per register.
// Notes:   Definitions only; included by the package and the design.
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH

// Register byte addresses.
`define SCG_ADDR_DIV1 32'h40001808
`define SCG_ADDR_DIV2 32'h4000180c
`define SCG_ADDR_CLKOUT 32'h40001810
`define SCG_ADDR_MON 32'h40001814
`define SCG_ADDR_EN1 32'h40001820
`define SCG_ADDR_EN2 32'h40001824
`define SCG_ADDR_SEL 32'h40001840

// Writable bits of each register; all other bits read as zero.
`define SCG_DIV1_MASK 32'h00000077
`define SCG_DIV2_MASK 32'h00000033
`define SCG_CLKOUT_MASK 32'h000000ff
`define SCG_MON_CTRL_MASK 32'h000000e3
`define SCG_MON_W1C_MASK 32'h0000000c
`define SCG_EN1_MASK 32'hc3c7713f
`define SCG_EN2_MASK 32'hd9ffbdc7
`define SCG_SEL_MASK 32'h03003fc1

// Field positions.
`define SCG_MON_RES_BIT 3
`define SCG_MON_IRQ_BIT 2
`define SCG_EN2_DATA_FLASH_BIT 30
`define SCG_EN2_CODE_FLASH_BIT 19
`define SCG_EN2_WATCHDOG_BIT 17
`define SCG_EN2_CALENDAR_BIT 11

// Reset value and last valid divider codes.
`define SCG_EN2_RST 32'h00010000
`define SCG_SLOW_LAST_CODE 3'h4
`define SCG_CORE_LAST_CODE 3'h4

// Monitor window: sixteen watchdog RC edges, a minimum edge count in it.
`define SCG_MON_WIN_LAST 4'hf
`define SCG_MON_MIN_EDGES 7'h08

`endif

//--- hw/scg_pkg.sv
// Purpose: Types of the system clock divide, monitor and gating block.
// Assumes: Constants come from scg_map.svh.
// Notes:   The block state is one packed struct, except the calendar gate bit.
`include "scg_map.svh"

package scg_pkg;

  // Oscillator pins, all asynchronous to the system clock.
  typedef struct packed {
    logic extSub;
    logic extMain;
    logic watchdogRc;
    logic fastRc;
  } scg_osc_t;

  typedef enum logic [1:0] {MSRC_FAST, MSRC_EXT_MAIN, MSRC_SUB,
                            MSRC_WDT} scg_main_src_t;
  typedef enum logic [1:0] {MON_MAIN, MON_FAST, MON_EXT_MAIN,
                            MON_SUB} scg_mon_src_t;
  typedef enum logic [1:0] {ACT_FLAGS, ACT_RESET, ACT_FORCE,
                            ACT_UNUSED} scg_mon_act_t;
  typedef enum logic [2:0] {OSRC_MAIN, OSRC_WDT, OSRC_FAST, OSRC_CORE,
                            OSRC_PERIPH} scg_out_src_t;
  typedef enum logic [2:0] {REG_NONE, REG_DIV1, REG_DIV2, REG_CLKOUT,
                            REG_MON, REG_EN1, REG_EN2, REG_SEL} scg_reg_t;

  typedef struct packed {
    logic [2:0] slowDiv;
    logic [2:0] coreDiv;
    logic [1:0] tickDiv;
    logic [1:0] perDiv;
    logic outEn;
    logic outIdle;
    logic [2:0] outDiv;
    logic [2:0] outSrc;
    logic monitor_enable;
    logic [1:0] monAct;
    logic monRes;
    logic monIrq;
    logic [1:0] monSrc;
    logic [31:0] en1;
    logic [31:0] en2;
    logic [31:0] clkSel;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] coreCnt;
    logic [2:0] perCnt;
    logic [2:0] tickCnt;
    logic [9:0] slowCnt;
    logic [6:0] outCnt;
    logic coreTick;
    logic perTick;
    logic sysTick;
    logic slowTick;
    logic clkOutPin;
    logic [3:0] winCnt;
    logic [6:0] edgeCnt;
    logic inFlag;
    logic forceWdt;
    logic resetReq;
    logic armed;
    logic [31:0] rdata;
    logic slvErr;
  } scg_state_t;

endpackage

//--- hw/scg_clock_control.sv
// Purpose: Clock dividers, clock output pin, clock monitor and peripheral
//          clock gating, programmed over APB.
// Assumes: The main clock is sys_clk; derived clocks leave as one-cycle
//          enable strobes. Oscillator pins are asynchronous.
// Notes:
// Notes on behaviour
// - Slow path tick is main divided 64..1024 for codes 0..4; others stop.
// - Core tick divides main by 16,8,4,2,1; codes above 4 divide by one.
// - Tick timer strobe is core tick divided by 1, 2, 4 or 8.
// - Peripheral tick is core tick divided by 1, 2, 4 or 8.
// - Pin carries divided clock when enabled, otherwise the idle level.
// - Clock output divides its source by two to the divider code.
// - Output source: main, watchdog RC, fast RC, core, peripheral, else none.
// - Disabling the monitor clears its counters, in-flag and both flags.
// - Failure action: flags only, reset, or force watchdog RC when main.
// - Result flag shows monitored clock ready; writing one clears it.
// - Interrupt flag sets on failure only when main is monitored; W1C.
// - Monitored source: main, fast RC, external main, external sub.
// - A peripheral gets its clock only while its enable bit is one.
// - Gated-off peripherals need not honour register accesses.
// - Flash gate bits ignore writes while their flash operation runs.
// - Watchdog RC stays on when the nonvolatile option enables it.
// - Calendar gate bit is cleared only by the deepest reset.
// - Main source codes: fast RC, external main, external sub, watchdog RC.
`timescale 1ns/1ps
`default_nettype none
`include "scg_map.svh"

module scg_clock_control
  import scg_pkg::*;
#(
  parameter logic [6:0] MON_MIN_EDGES = `SCG_MON_MIN_EDGES
)
(
  // Clock, resets and clock enable.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rstDeep,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Oscillator pins and system status.
  input wire scg_osc_t oscPins,
  input wire logic [1:0] mainSourceSelect,
  input wire logic codeFlashBusy,
  input wire logic dataFlashBusy,
  input wire logic wdtCfgOn,
  // Derived clock strobes.
  output logic coreTick,
  output logic periphTick,
  output logic sysTickTick,
  output logic slowTick,
  // Peripheral gating.
  output logic [31:0] periphGate1,
  output logic [31:0] periphGate2,
  output logic [31:0] periphTick1,
  output logic [31:0] periphTick2,
  output logic [31:0] periphClkSelect,
  output logic watchdogRcKeepOn,
  // Clock output pin, monitor results.
  output logic clkOutPin,
  output logic [1:0] effMainSource,
  output logic monResetReq
);

  localparam scg_state_t RST_STATE = '{en2: `SCG_EN2_RST, default: '0};

  scg_state_t s_r;
  scg_state_t s_nxt;
  logic calendarGate_r;
  scg_reg_t regSel;
  logic apbWr;
  logic apbCap;
  logic [31:0] div1Word;
  logic [31:0] div2Word;
  logic [31:0] outWord;
  logic [31:0] monWord;
  logic [31:0] en2Word;
  logic [31:0] wrVal;
  logic [31:0] en2Mask;
  logic [3:0] oscEdge;
  logic [3:0] coreLim;
  logic [9:0] slowLim;
  logic [6:0] outMask;
  logic outEvt;
  logic monEdge;
  logic monOk;
  logic [1:0] mainSel;

  // Byte-lane merge of a write into a register under its writable mask.
  function automatic logic [31:0] mergeWrite(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0] strb,
                                             input logic [31:0] wmask);
    logic [31:0] laneMask;
    for (int i = 0; i < 4; i++)
    begin
      laneMask[8*i +: 8] = {8{strb[i]}};
    end
    return (oldVal & ~(laneMask & wmask)) | (newVal & laneMask & wmask);
  endfunction

  // Last count of a 1/2/4/8 divider running on core ticks.
  function automatic logic [2:0] tickLimit(input logic [1:0] code);
    return 3'((4'h1 << code) - 4'h1);
  endfunction

  // Register decode, shared by the read and the write path.
  always_comb
  begin
    unique case (paddr)
      `SCG_ADDR_DIV1: regSel = REG_DIV1;
      `SCG_ADDR_DIV2: regSel = REG_DIV2;
      `SCG_ADDR_CLKOUT: regSel = REG_CLKOUT;
      `SCG_ADDR_MON: regSel = REG_MON;
      `SCG_ADDR_EN1: regSel = REG_EN1;
      `SCG_ADDR_EN2: regSel = REG_EN2;
      `SCG_ADDR_SEL: regSel = REG_SEL;
      default: regSel = REG_NONE;
    endcase
  end

  // Read data is captured at setup, so the access phase never waits.
  assign apbCap = ce && psel && (!penable || !s_r.armed);
  assign apbWr = ce && psel && penable && s_r.armed && pwrite;
  assign pready = ce && psel && penable && s_r.armed;
  assign prdata = s_r.rdata;
  assign pslverr = s_r.slvErr;

  // Register words as software sees them; reserved bits read zero.
  assign div1Word = {25'h0, s_r.slowDiv, 1'b0, s_r.coreDiv};
  assign div2Word = {26'h0, s_r.tickDiv, 2'b00, s_r.perDiv};
  assign outWord = {24'h0, s_r.outEn, s_r.outIdle, s_r.outDiv, s_r.outSrc};
  assign monWord = {24'h0, s_r.monitor_enable, s_r.monAct, 1'b0, s_r.monRes,
                    s_r.monIrq, s_r.monSrc};
  assign en2Word = {s_r.en2[31:12], calendarGate_r, s_r.en2[10:0]};

  // Flash gate bits are locked while their flash is busy.
  always_comb
  begin
    en2Mask = `SCG_EN2_MASK;
    en2Mask[`SCG_EN2_CALENDAR_BIT] = 1'b0;
    if (codeFlashBusy)
    begin
      en2Mask[`SCG_EN2_CODE_FLASH_BIT] = 1'b0;
    end
    if (dataFlashBusy)
    begin
      en2Mask[`SCG_EN2_DATA_FLASH_BIT] = 1'b0;
    end
  end

  // Effective main source; a forced switch overrides software's choice.
  assign mainSel = s_r.forceWdt ? MSRC_WDT : mainSourceSelect;
  assign effMainSource = mainSel;
  assign oscEdge = s_r.sync2 & ~s_r.sync3;

  // Core divider: codes 0..4 give 16,8,4,2,1, the rest divide by one.
  always_comb
  begin
    if (s_r.coreDiv < `SCG_CORE_LAST_CODE)
    begin
      coreLim = 4'((5'h10 >> s_r.coreDiv) - 5'h01);
    end
    else
    begin
      coreLim = 4'h0;
    end
    slowLim = 10'((11'h040 << s_r.slowDiv) - 11'h001);
    outMask = 7'((8'h01 << s_r.outDiv) - 8'h01);
  end

  // Source events for the output divider; reserved codes give none.
  always_comb
  begin
    unique case (s_r.outSrc)
      OSRC_MAIN: outEvt = 1'b1;
      OSRC_WDT: outEvt = oscEdge[1];
      OSRC_FAST: outEvt = oscEdge[0];
      OSRC_CORE: outEvt = s_r.coreTick;
      OSRC_PERIPH: outEvt = s_r.perTick;
      default: outEvt = 1'b0;
    endcase
  end

  // Edge of the monitored clock; main follows the effective source.
  always_comb
  begin
    unique case (s_r.monSrc)
      MON_MAIN:
      begin
        unique case (mainSel)
          MSRC_FAST: monEdge = oscEdge[0];
          MSRC_EXT_MAIN: monEdge = oscEdge[2];
          MSRC_SUB: monEdge = oscEdge[3];
          MSRC_WDT: monEdge = oscEdge[1];
        endcase
      end
      MON_FAST: monEdge = oscEdge[0];
      MON_EXT_MAIN: monEdge = oscEdge[2];
      MON_SUB: monEdge = oscEdge[3];
    endcase
    monOk = s_r.inFlag && (s_r.edgeCnt >= MON_MIN_EDGES);
  end

  // Next state: synchronisers, dividers, output, registers, monitor.
  always_comb
  begin
    s_nxt = s_r;
    wrVal = 32'h0;
    s_nxt.resetReq = 1'b0;
    s_nxt.sync1 = oscPins;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    // Core tick from the main clock.
    s_nxt.coreTick = (s_r.coreCnt >= coreLim);
    s_nxt.coreCnt = s_nxt.coreTick ? 4'h0 : s_r.coreCnt + 4'h1;
    // Peripheral and tick timer strobes count core ticks.
    s_nxt.perTick = 1'b0;
    s_nxt.sysTick = 1'b0;
    if (s_r.coreTick)
    begin
      s_nxt.perTick = (s_r.perCnt >= tickLimit(s_r.perDiv));
      s_nxt.perCnt = s_nxt.perTick ? 3'h0 : s_r.perCnt + 3'h1;
      s_nxt.sysTick = (s_r.tickCnt >= tickLimit(s_r.tickDiv));
      s_nxt.tickCnt = s_nxt.sysTick ? 3'h0 : s_r.tickCnt + 3'h1;
    end
    // Slow path; a reserved code parks the divider.
    if (s_r.slowDiv > `SCG_SLOW_LAST_CODE)
    begin
      s_nxt.slowCnt = 10'h0;
      s_nxt.slowTick = 1'b0;
    end
    else
    begin
      s_nxt.slowTick = (s_r.slowCnt >= slowLim);
      s_nxt.slowCnt = s_nxt.slowTick ? 10'h0 : s_r.slowCnt + 10'h1;
    end
    // Clock output: period of two to the code source events.
    if (!s_r.outEn)
    begin
      s_nxt.outCnt = 7'h0;
      s_nxt.clkOutPin = s_r.outIdle;
    end
    else if (s_r.outDiv == 3'h0)
    begin
      s_nxt.clkOutPin = outEvt;
    end
    else
    begin
      if (outEvt)
      begin
        s_nxt.outCnt = (s_r.outCnt + 7'h1) & outMask;
      end
      s_nxt.clkOutPin = ~s_nxt.outCnt[s_r.outDiv - 3'h1];
    end
    // Register writes.
    if (apbWr)
    begin
      unique case (regSel)
        REG_DIV1:
        begin
          wrVal = mergeWrite(div1Word, pwdata, pstrb, `SCG_DIV1_MASK);
          s_nxt.slowDiv = wrVal[6:4];
          s_nxt.coreDiv = wrVal[2:0];
        end
        REG_DIV2:
        begin
          wrVal = mergeWrite(div2Word, pwdata, pstrb, `SCG_DIV2_MASK);
          s_nxt.tickDiv = wrVal[5:4];
          s_nxt.perDiv = wrVal[1:0];
        end
        REG_CLKOUT:
        begin
          wrVal = mergeWrite(outWord, pwdata, pstrb, `SCG_CLKOUT_MASK);
          {s_nxt.outEn, s_nxt.outIdle} = wrVal[7:6];
          s_nxt.outDiv = wrVal[5:3];
          s_nxt.outSrc = wrVal[2:0];
        end
        REG_MON:
        begin
          wrVal = mergeWrite(monWord, pwdata, pstrb, `SCG_MON_CTRL_MASK);
          s_nxt.monitor_enable = wrVal[7];
          s_nxt.monAct = wrVal[6:5];
          s_nxt.monSrc = wrVal[1:0];
          // Only a written one clears; the set below still wins.
          if (pstrb[0] && pwdata[`SCG_MON_RES_BIT])
          begin
            s_nxt.monRes = 1'b0;
          end
          if (pstrb[0] && pwdata[`SCG_MON_IRQ_BIT])
          begin
            s_nxt.monIrq = 1'b0;
          end
        end
        REG_EN1: s_nxt.en1 = mergeWrite(s_r.en1, pwdata, pstrb,
                                        `SCG_EN1_MASK);
        REG_EN2: s_nxt.en2 = mergeWrite(s_r.en2, pwdata, pstrb, en2Mask);
        REG_SEL: s_nxt.clkSel = mergeWrite(s_r.clkSel, pwdata, pstrb,
                                           `SCG_SEL_MASK);
        default: s_nxt.en1 = s_r.en1;
      endcase
    end
    // Monitor: a window of sixteen watchdog RC edges judges the clock.
    if (!s_nxt.monitor_enable)
    begin
      s_nxt.winCnt = 4'h0;
      s_nxt.edgeCnt = 7'h0;
      s_nxt.inFlag = 1'b0;
      s_nxt.monRes = 1'b0;
      s_nxt.monIrq = 1'b0;
    end
    else
    begin
      if (monEdge)
      begin
        s_nxt.inFlag = 1'b1;
        if (s_r.edgeCnt != 7'h7f)
        begin
          s_nxt.edgeCnt = s_r.edgeCnt + 7'h1;
        end
      end
      if (oscEdge[1])
      begin
        s_nxt.winCnt = s_r.winCnt + 4'h1;
        if (s_r.winCnt == `SCG_MON_WIN_LAST)
        begin
          s_nxt.edgeCnt = 7'h0;
          s_nxt.inFlag = 1'b0;
          if (monOk)
          begin
            s_nxt.monRes = 1'b1;
          end
          else
          begin
            s_nxt.monRes = 1'b0;
            if (s_r.monSrc == MON_MAIN)
            begin
              s_nxt.monIrq = 1'b1;
            end
            unique case (s_r.monAct)
              ACT_RESET: s_nxt.resetReq = 1'b1;
              ACT_FORCE: s_nxt.forceWdt = s_r.forceWdt ||
                                          (s_r.monSrc == MON_MAIN);
              default: s_nxt.resetReq = 1'b0;
            endcase
          end
        end
      end
    end
    // Read data and error for the coming access phase.
    s_nxt.armed = apbCap || !(psel && penable && s_r.armed);
    if (apbCap)
    begin
      s_nxt.slvErr = (regSel == REG_NONE);
      unique case (regSel)
        REG_DIV1: s_nxt.rdata = div1Word;
        REG_DIV2: s_nxt.rdata = div2Word;
        REG_CLKOUT: s_nxt.rdata = outWord;
        REG_MON: s_nxt.rdata = monWord;
        REG_EN1: s_nxt.rdata = s_r.en1;
        REG_EN2: s_nxt.rdata = en2Word;
        REG_SEL: s_nxt.rdata = s_r.clkSel;
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    else if (!psel)
    begin
      s_nxt.armed = 1'b0;
    end
  end

  // All block state but the calendar gate; clock enable low freezes it.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= RST_STATE;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  // The calendar gate survives every reset except the deepest one.
  always_ff @(posedge sys_clk or posedge rstDeep)
  begin
    if (rstDeep)
    begin
      calendarGate_r <= 1'b0;
    end
    else if (ce && apbWr && regSel == REG_EN2 && pstrb[1])
    begin
      calendarGate_r <= pwdata[`SCG_EN2_CALENDAR_BIT];
    end
  end

  // Outputs; gated peripheral strobes stop as soon as a bit is cleared.
  assign coreTick = s_r.coreTick;
  assign periphTick = s_r.perTick;
  assign sysTickTick = s_r.sysTick;
  assign slowTick = s_r.slowTick;
  assign periphGate1 = s_r.en1;
  assign periphGate2 = en2Word;
  assign periphClkSelect = s_r.clkSel;
  assign clkOutPin = s_r.clkOutPin;
  assign monResetReq = s_r.resetReq;
  assign watchdogRcKeepOn = en2Word[`SCG_EN2_WATCHDOG_BIT] ||
                            wdtCfgOn;
  for (genvar g = 0; g < 32; g++)
  begin : gen_gate
    assign periphTick1[g] = s_r.perTick && s_r.en1[g];
    assign periphTick2[g] = s_r.perTick && en2Word[g];
  end

  // Checks on the dividers, output pin, monitor and gate locks.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic divWrite;
  assign divWrite = apbWr && (regSel == REG_DIV1 || regSel == REG_DIV2);

  chk_core_div_four: assert property (
    disable iff (rst || !ce || divWrite)
    (s_r.coreTick && s_r.coreDiv == 3'h2) |=> !s_r.coreTick [*3] ##1
    s_r.coreTick)
    else $error("Core tick spacing wrong for divide by four.");
  chk_slow_reserved: assert property (
    (ce && s_r.slowDiv > 3'h4) |=> !s_r.slowTick)
    else $error("Slow tick seen with a reserved code.");
  chk_per_div_two: assert property (
    disable iff (rst || !ce || divWrite)
    (s_r.perTick && s_r.perDiv == 2'h1 && s_r.coreDiv >= 3'h4) |=>
    !s_r.perTick ##1 s_r.perTick)
    else $error("Peripheral tick spacing wrong for divide by two.");
  chk_tick_follows_core: assert property (
    $rose(s_r.sysTick) |-> $past(s_r.coreTick))
    else $error("Tick timer strobe without a core tick.");
  chk_out_idle_level: assert property (
    (ce && !s_r.outEn) |=> s_r.clkOutPin == $past(s_r.outIdle))
    else $error("Clock output pin not at its idle level.");
  chk_out_none_src: assert property (
    (s_r.outEn && s_r.outSrc > 3'h4 && s_r.outDiv != 3'h0) ##1
    (s_r.outEn && s_r.outSrc > 3'h4 && s_r.outDiv != 3'h0) |=>
    $stable(s_r.clkOutPin))
    else $error("Clock output moves with no source selected.");
  chk_mon_disable_clear: assert property (
    (ce && !s_nxt.monitor_enable) |=> (!s_r.monRes && !s_r.monIrq &&
    s_r.edgeCnt == 7'h0 && s_r.winCnt == 4'h0 && !s_r.inFlag))
    else $error("Disabled monitor kept state.");
  chk_irq_main_only: assert property (
    $rose(s_r.monIrq) |-> $past(s_r.monSrc) == MON_MAIN)
    else $error("Monitor interrupt flag set for a non-main clock.");
  chk_force_cause: assert property (
    $rose(s_r.forceWdt) |-> ($past(s_r.monAct) == ACT_FORCE &&
    $past(s_r.monSrc) == MON_MAIN) ##0 effMainSource == MSRC_WDT)
    else $error("Forced switch without its cause.");
  chk_reset_action: assert property (
    s_r.resetReq |-> $past(s_r.monAct) == ACT_RESET ##1 !s_r.resetReq)
    else $error("Reset request without reset action or too long.");
  chk_w1c_zero_keeps: assert property (
    (apbWr && regSel == REG_MON && !pwdata[3] && pwdata[7] &&
    !(oscEdge[1] && s_r.winCnt == `SCG_MON_WIN_LAST)) |=>
    (s_r.monRes || !$past(s_r.monRes)))
    else $error("Writing zero cleared the result flag.");
  chk_flash_lock: assert property (
    (apbWr && regSel == REG_EN2 && codeFlashBusy) |=>
    s_r.en2[19] == $past(s_r.en2[19]))
    else $error("Code flash gate changed during a flash operation.");

  cov_monitor_fail: cover property (s_r.monitor_enable ##1 $rose(s_r.monIrq));
  cov_force_wdt: cover property ($rose(s_r.forceWdt));
  cov_clkout_toggle: cover property (s_r.outEn && $rose(s_r.clkOutPin));
  cov_core_div16: cover property (s_r.coreTick && s_r.coreDiv == 3'h0);

endmodule
`default_nettype wire

//--- bench/scg_osc_model.sv
// Purpose: Oscillator pins that feed the clock block.
// Assumes: Both RC oscillators are much slower than the system clock.
// Notes: The fast RC stops low while fastRun is low, to starve the monitor.
`timescale 1ns/1ps
`default_nettype none
module scg_osc_model
  import scg_pkg::*;
(
  // Run control and pins.
  input wire logic fastRun,
  output var scg_osc_t oscPins
);
  // Half periods fall on falling clock edges, so no race with sampling.
  initial
  begin
    oscPins = '0;
    fork
      forever #160 oscPins.watchdogRc = ~oscPins.watchdogRc;
      forever #120 oscPins.fastRc = fastRun & ~oscPins.fastRc;
      forever #200 oscPins.extMain = ~oscPins.extMain;
    join
  end
endmodule
`default_nettype wire

//--- bench/sysclk_divide_monitor_gating_tb.sv
// Purpose: Self-checking bench of the divider, clock output and monitor.
// Assumes: APB answers are awaited, never counted on.
// Notes: A watcher compares read data with the oldest queued note.
`timescale 1ns/1ps
`default_nettype none
`include "scg_map.svh"
module sysclk_divide_monitor_gating_tb
  import scg_pkg::*;
;
  logic sys_clk = 0, rst = 1, rstDeep = 1, psel = 0, penable = 0;
  logic pwrite = 0, codeFlashBusy = 0, fastRun = 1, pready, pslverr;
  logic coreTick, periphTick, sysTickTick, slowTick, clkOutPin;
  logic monResetReq, wdtCfgOn = 0, keepOn;
  logic [1:0] mainSel = 2'h0, effMain;
  logic [31:0] paddr = '0, pwdata = '0, prdata, periphGate1, periphGate2;
  logic [31:0] lfsr = 32'h7cec;
  logic [31:0] expQ[$];
  scg_osc_t oscPins;
  int bad_count = 0, checks = 0, cyc = 0, cnt[6];
  int outExp[8] = '{128, 16, 0, 128, 16, 0, 0, 0};

  scg_clock_control scg_clock_control_inst (.sys_clk, .rst, .rstDeep,
    .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .pready, .prdata, .pslverr, .oscPins, .mainSourceSelect(mainSel),
    .codeFlashBusy, .dataFlashBusy(1'b0), .wdtCfgOn, .coreTick,
    .periphTick, .sysTickTick, .slowTick, .periphGate1, .periphGate2,
    .periphTick1(), .periphTick2(), .periphClkSelect(),
    .watchdogRcKeepOn(keepOn), .clkOutPin, .effMainSource(effMain),
    .monResetReq);
  scg_osc_model scg_osc_model_inst (.fastRun, .oscPins);

  // Free-running 25 MHz system clock.
  initial
    forever #20 sys_clk = ~sys_clk;

  function automatic logic [31:0] nextLfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; it holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // Ready is judged at the rising edge, where the write also lands.
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(0, a, 32'h0);
  endtask

  // Counts output rises and strobe pulses over a window of n cycles.
  task automatic meas(input int n);
    logic last;
    logic [4:0] v;
    cnt = '{default: 0};
    last = clkOutPin;
    repeat (n)
    begin
      @(negedge sys_clk);
      v = {monResetReq, sysTickTick, periphTick, slowTick, coreTick};
      cnt[0] += int'(clkOutPin & ~last);
      last = clkOutPin;
      for (int i = 0; i < 5; i++)
        cnt[i + 1] += int'(v[i]);
    end
  endtask

  // Read data is taken at the completing edge, before the bus moves on.
  always @(posedge sys_clk)
    if (psel && penable && pready && !pwrite)
      check(prdata, expQ.pop_front());

  // A hang is cut short well above the expected run of about 33k cycles.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      end_sim();
    end
  end

  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    rstDeep <= 0;
    rd(`SCG_ADDR_DIV1, 32'h0);
    rd(`SCG_ADDR_EN2, `SCG_EN2_RST);
    rd(32'h40001818, 32'h0);
    check({31'h0, pslverr}, 32'h1);
    // The long wait honours the core divider settling time and lets
    // the slowest divider reach a steady period before counting.
    for (int c = 0; c < 8; c++)
    begin
      apb(1, `SCG_ADDR_DIV1, c << 4 | c);
      repeat (1100) @(posedge sys_clk);
      meas(2048);
      check(cnt[1], c > 4 ? 2048 : 2048 >> (4 - c));
      check(cnt[2], c > 4 ? 0 : 32 >> c);
    end
    for (int c = 0; c < 4; c++)
    begin
      apb(1, `SCG_ADDR_DIV2, c << 4 | c);
      repeat (10) @(posedge sys_clk);
      meas(256);
      check(cnt[3], 256 >> c);
      check(cnt[4], 256 >> c);
    end
    $display("divider test done");
    for (int s = 0; s < 16; s++)
    begin
      apb(1, `SCG_ADDR_CLKOUT, s < 8 ? 32'h88 | s : 32'h80 | (s - 8) << 3);
      repeat (40) @(posedge sys_clk);
      meas(256);
      if (s < 8 && s != 2)
        check(cnt[0], outExp[s]);
      if (s > 8)
        check(cnt[0], 256 >> (s - 8));
    end
    apb(1, `SCG_ADDR_CLKOUT, 32'h40);
    repeat (2) @(posedge sys_clk);
    check({31'h0, clkOutPin}, 32'h1);
    apb(1, `SCG_ADDR_CLKOUT, 32'h0);
    repeat (2) @(posedge sys_clk);
    check({31'h0, clkOutPin}, 32'h0);
    $display("clock output test done");
    repeat (3)
    begin
      lfsr = nextLfsr(lfsr);
      apb(1, `SCG_ADDR_EN1, lfsr);
      rd(`SCG_ADDR_EN1, lfsr & `SCG_EN1_MASK);
      check(periphGate1, lfsr & `SCG_EN1_MASK);
    end
    codeFlashBusy <= 1;
    apb(1, `SCG_ADDR_EN2, 32'h00080000);
    rd(`SCG_ADDR_EN2, 32'h0);
    codeFlashBusy <= 0;
    apb(1, `SCG_ADDR_EN2, 32'h00080800);
    rst <= 1;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    rd(`SCG_ADDR_EN2, 32'h00010800);
    $display("gating test done");
    // Fast RC watched: it passes while running, fails once stopped.
    apb(1, `SCG_ADDR_MON, 32'h81);
    repeat (300) @(posedge sys_clk);
    rd(`SCG_ADDR_MON, 32'h89);
    apb(1, `SCG_ADDR_MON, 32'h81);
    rd(`SCG_ADDR_MON, 32'h89);
    apb(1, `SCG_ADDR_MON, 32'h89);
    rd(`SCG_ADDR_MON, 32'h81);
    repeat (300) @(posedge sys_clk);
    apb(1, `SCG_ADDR_MON, 32'h0);
    rd(`SCG_ADDR_MON, 32'h0);
    fastRun <= 0;
    apb(1, `SCG_ADDR_MON, 32'ha1);
    repeat (300) @(posedge sys_clk);
    rd(`SCG_ADDR_MON, 32'ha1);
    meas(512);
    check(cnt[5] > 0, 32'h1);
    // Main (fast RC, stopped) watched with forcing: the first window
    // fails and forces the watchdog RC, the next one passes on it.
    apb(1, `SCG_ADDR_MON, 32'h0);
    apb(1, `SCG_ADDR_MON, 32'hc0);
    repeat (300) @(posedge sys_clk);
    rd(`SCG_ADDR_MON, 32'hcc);
    check({30'h0, effMain}, 32'h3);
    apb(1, `SCG_ADDR_DIV1, 32'h4);
    apb(1, `SCG_ADDR_DIV2, 32'h0);
    mainSel <= 2'h3;
    check({31'h0, keepOn}, 32'h0);
    wdtCfgOn <= 1;
    apb(1, `SCG_ADDR_MON, 32'h0);
    check({31'h0, keepOn}, 32'h1);
    $display("monitor test done");
    end_sim();
  end
endmodule
`default_nettype wire
